/* hw/tmr_cfg_pkg.sv */
package tmr_cfg_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_OUT_MODE = 8'h00;
	localparam logic [7:0] OFS_OUT_LEVEL = 8'h04;
	localparam logic [7:0] OFS_OUT_EN = 8'h08;
	localparam logic [7:0] OFS_NOISE_FILT = 8'h0c;
	localparam logic [7:0] OFS_CH2_MODE = 8'h10;
	localparam logic [7:0] OFS_SW_TRIG = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CH1_BIT = 1;
	localparam int SW_TRIG_BIT = 0;
	localparam logic [15:0] RST_OUT_MODE = 16'h0000;
	localparam logic [15:0] RST_OUT_LEVEL = 16'h0000;
	localparam logic [15:0] RST_OUT_EN = 16'h0000;
	localparam logic [7:0] RST_NOISE_FILT = 8'h00;
	localparam logic [15:0] RST_CH2_MODE = 16'h0000;
	localparam logic [15:0] CH2_MODE_WMASK = 16'hdfcf;
	localparam int FILT_LEN = 3;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] OPCLK_A = 2'h0;
	localparam logic [1:0] OPCLK_C = 2'h1;
	localparam logic [1:0] OPCLK_B = 2'h2;
	localparam logic [1:0] OPCLK_D = 2'h3;
	localparam logic [2:0] TRIG_SW_ONLY = 3'h0;
	localparam logic [2:0] TRIG_ONE_EDGE = 3'h1;
	localparam logic [2:0] TRIG_BOTH_EDGE = 3'h2;
	localparam logic [2:0] TRIG_MASTER = 3'h4;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH_LOW = 2'h2;
	localparam logic [1:0] EDGE_BOTH_HIGH = 2'h3;

	typedef struct packed {
		logic [1:0] opclk_sel;
		logic rsv13;
		logic count_clk_src;
		logic lead_role_bit;
		logic [2:0] trig_sel;
		logic [1:0] edge_sel;
		logic [1:0] rsv5_4;
		logic [3:0] op_mode;
	} ch2_mode_t;

	typedef struct packed {
		logic start;
		logic capture;
		logic count_tick;
	} ch2_evt_t;

endpackage : tmr_cfg_pkg

/* hw/pin_noise_filter.sv */
module pin_noise_filter #(
	parameter int LEN = tmr_cfg_pkg::FILT_LEN
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic filt_on,
	input wire logic pin_in,
	output logic pin_out
);

	logic [LEN-1:0] hist;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist <= '0;
		end else if (clk_en) begin
			hist <= {hist[LEN-2:0], pin_in};
		end
	end

	// Level passes only once stable for LEN samples when filtering
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b0;
		end else if (clk_en) begin
			if (!filt_on) begin
				pin_out <= pin_in;
			end else if (&hist) begin
				pin_out <= 1'b1;
			end else if (~|hist) begin
				pin_out <= 1'b0;
			end
		end
	end

endmodule : pin_noise_filter

/* hw/pin_edge_detect.sv */
module pin_edge_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic rise,
	output logic fall
);

	logic last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 1'b0;
		end else if (clk_en) begin
			last <= pin_in;
		end
	end

	assign rise = clk_en && pin_in && !last;
	assign fall = clk_en && !pin_in && last;

endmodule : pin_edge_detect

/* hw/timer_channel_cfg.sv */
// Behaviour
// - Output-mode bit 1 picks channel 1 master (0) or slave (1) output
// - Output-level bit 1 holds channel 1 output level, 0 low, 1 high
// - Output-enable bit 1 lets counting drive channel 1 output when set
// - Noise-filter bit 1 turns channel 1 input filter on or off
// - Channel 2 bits 15:14 pick clock a, c, b, d for 00..11
// - Channel 2 bit 12: count operation clock (0) or input edges (1)
// - Channel 2 bit 11 set marks master role, clear independent/slave
// - Trigger code 000: start only by software trigger
// - Trigger code 001: valid input edge starts and captures
// - Trigger code 010: one input edge starts, other edge captures
// - Trigger code 100: trigger comes from master channel interrupt
// - Edge bits 7:6: fall, rise, both low width, both high width
//
// The APB register port and the register addresses are this design's own decisions.
module timer_channel_cfg (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] prescaled_ticks,
	input wire logic ch1_input_pin,
	input wire logic ch2_input_pin,
	input wire logic ch1_cnt_toggle,
	input wire logic ch1_cnt_set,
	input wire logic ch1_cnt_clear,
	input wire logic master_irq,
	output logic ch1_output_pin,
	output logic ch1_input_clean,
	output logic ch2_lead_role_bit,
	output logic ch2_start_trig,
	output logic ch2_capture_trig,
	output logic ch2_count_tick
);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [15:0] output_mode_reg;
	logic [15:0] output_level_reg;
	logic [15:0] output_enable_reg;
	logic [7:0] noise_filter_reg;
	tmr_cfg_pkg::ch2_mode_t ch2_mode_reg;
	logic sw_trig;
	logic access;
	logic wr;
	logic mapped;

	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign mapped = paddr inside {tmr_cfg_pkg::OFS_OUT_MODE,
		tmr_cfg_pkg::OFS_OUT_LEVEL, tmr_cfg_pkg::OFS_OUT_EN,
		tmr_cfg_pkg::OFS_NOISE_FILT, tmr_cfg_pkg::OFS_CH2_MODE,
		tmr_cfg_pkg::OFS_SW_TRIG, tmr_cfg_pkg::OFS_STATUS};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : hit

	// One wait state: answer comes in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite) begin
				case (paddr)
					tmr_cfg_pkg::OFS_OUT_MODE:
						prdata <= {16'h0000, output_mode_reg};
					tmr_cfg_pkg::OFS_OUT_LEVEL:
						prdata <= {16'h0000, output_level_reg};
					tmr_cfg_pkg::OFS_OUT_EN:
						prdata <= {16'h0000, output_enable_reg};
					tmr_cfg_pkg::OFS_NOISE_FILT:
						prdata <= {24'h000000, noise_filter_reg};
					tmr_cfg_pkg::OFS_CH2_MODE:
						prdata <= {16'h0000, ch2_mode_reg};
					tmr_cfg_pkg::OFS_STATUS:
						prdata <= {29'h0000_0000, ch1_input_clean,
							ch2_input_pin, ch1_output_pin};
					default:
						prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_mode_reg <= tmr_cfg_pkg::RST_OUT_MODE;
			output_enable_reg <= tmr_cfg_pkg::RST_OUT_EN;
			noise_filter_reg <= tmr_cfg_pkg::RST_NOISE_FILT;
			ch2_mode_reg <= tmr_cfg_pkg::RST_CH2_MODE;
		end else if (clk_en && wr) begin
			if (hit(paddr, tmr_cfg_pkg::OFS_OUT_MODE)) begin
				output_mode_reg <= pwdata[15:0];
			end
			if (hit(paddr, tmr_cfg_pkg::OFS_OUT_EN)) begin
				output_enable_reg <= pwdata[15:0];
			end
			if (hit(paddr, tmr_cfg_pkg::OFS_NOISE_FILT)) begin
				noise_filter_reg <= pwdata[7:0];
			end
			if (hit(paddr, tmr_cfg_pkg::OFS_CH2_MODE)) begin
				ch2_mode_reg <= pwdata[15:0] & tmr_cfg_pkg::CH2_MODE_WMASK;
			end
		end
	end

	// Software trigger is a write-one pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_trig <= 1'b0;
		end else if (clk_en) begin
			sw_trig <= wr && hit(paddr, tmr_cfg_pkg::OFS_SW_TRIG) &&
				pwdata[tmr_cfg_pkg::SW_TRIG_BIT];
		end
	end

	// ------------------------------------------------------------
	// Channel 1 output
	// ------------------------------------------------------------
	logic ch1_output_mode_bit;
	logic ch1_output_enable_bit;
	logic ch1_noise_filter_bit;
	logic ch1_output_level;

	assign ch1_output_mode_bit = output_mode_reg[tmr_cfg_pkg::CH1_BIT];
	assign ch1_output_enable_bit = output_enable_reg[tmr_cfg_pkg::CH1_BIT];
	assign ch1_noise_filter_bit = noise_filter_reg[tmr_cfg_pkg::CH1_BIT];
	assign ch1_output_level = output_level_reg[tmr_cfg_pkg::CH1_BIT];

	// Direct writes to an enabled bit are ignored; counting owns it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_level_reg <= tmr_cfg_pkg::RST_OUT_LEVEL;
		end else if (clk_en) begin
			for (int i = 0; i < 16; i++) begin
				if (wr && hit(paddr, tmr_cfg_pkg::OFS_OUT_LEVEL) &&
					!output_enable_reg[i]) begin
					output_level_reg[i] <= pwdata[i];
				end
			end
			if (ch1_output_enable_bit) begin
				if (!ch1_output_mode_bit && ch1_cnt_toggle) begin
					output_level_reg[tmr_cfg_pkg::CH1_BIT] <= !ch1_output_level;
				end else if (ch1_output_mode_bit && ch1_cnt_set) begin
					output_level_reg[tmr_cfg_pkg::CH1_BIT] <= 1'b1;
				end else if (ch1_output_mode_bit && ch1_cnt_clear) begin
					output_level_reg[tmr_cfg_pkg::CH1_BIT] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch1_output_pin <= 1'b0;
		end else if (clk_en) begin
			ch1_output_pin <= ch1_output_level;
		end
	end

	pin_noise_filter #(
		.LEN(tmr_cfg_pkg::FILT_LEN)
	) u_ch1_filter (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.filt_on(ch1_noise_filter_bit),
		.pin_in(ch1_input_pin),
		.pin_out(ch1_input_clean)
	);

	// ------------------------------------------------------------
	// Channel 2 clock and trigger selection
	// ------------------------------------------------------------
	logic ch2_rise;
	logic ch2_fall;
	logic opclk_tick;
	logic valid_edge;
	logic start_edge;
	logic capture_edge;
	tmr_cfg_pkg::ch2_evt_t next_evt;

	pin_edge_detect u_ch2_edge (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin_in(ch2_input_pin),
		.rise(ch2_rise),
		.fall(ch2_fall)
	);

	always_comb begin
		case (ch2_mode_reg.opclk_sel)
			tmr_cfg_pkg::OPCLK_A: opclk_tick = prescaled_ticks[0];
			tmr_cfg_pkg::OPCLK_B: opclk_tick = prescaled_ticks[1];
			tmr_cfg_pkg::OPCLK_C: opclk_tick = prescaled_ticks[2];
			default: opclk_tick = prescaled_ticks[3];
		endcase
	end

	always_comb begin
		case (ch2_mode_reg.edge_sel)
			tmr_cfg_pkg::EDGE_FALL: valid_edge = ch2_fall;
			tmr_cfg_pkg::EDGE_RISE: valid_edge = ch2_rise;
			default: valid_edge = ch2_rise || ch2_fall;
		endcase
		// Low width starts on falling; high width starts on rising
		start_edge = ch2_mode_reg.edge_sel[0] ? ch2_rise : ch2_fall;
		capture_edge = ch2_mode_reg.edge_sel[0] ? ch2_fall : ch2_rise;
	end

	always_comb begin
		next_evt.count_tick = ch2_mode_reg.count_clk_src ?
			valid_edge : opclk_tick;
		case (ch2_mode_reg.trig_sel)
			tmr_cfg_pkg::TRIG_SW_ONLY: begin
				next_evt.start = sw_trig;
				next_evt.capture = 1'b0;
			end
			tmr_cfg_pkg::TRIG_ONE_EDGE: begin
				next_evt.start = sw_trig || valid_edge;
				next_evt.capture = valid_edge;
			end
			tmr_cfg_pkg::TRIG_BOTH_EDGE: begin
				next_evt.start = sw_trig || start_edge;
				next_evt.capture = capture_edge;
			end
			tmr_cfg_pkg::TRIG_MASTER: begin
				next_evt.start = sw_trig || master_irq;
				next_evt.capture = master_irq;
			end
			default: begin
				// Prohibited codes: only software start is kept
				next_evt.start = sw_trig;
				next_evt.capture = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch2_start_trig <= 1'b0;
			ch2_capture_trig <= 1'b0;
			ch2_count_tick <= 1'b0;
			ch2_lead_role_bit <= 1'b0;
		end else if (clk_en) begin
			ch2_start_trig <= next_evt.start;
			ch2_capture_trig <= next_evt.capture;
			ch2_count_tick <= next_evt.count_tick;
			ch2_lead_role_bit <= ch2_mode_reg.lead_role_bit;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_mode_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch1_output_enable_bit && !ch1_output_mode_bit &&
		ch1_cnt_toggle ##1 clk_en |=> ch1_output_pin != $past(ch1_output_pin))
		else $error("master mode toggle did not reach output pin");

	chk_level_write: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && wr && hit(paddr, tmr_cfg_pkg::OFS_OUT_LEVEL) &&
		!ch1_output_enable_bit ##1 clk_en |=> ch1_output_pin == $past(pwdata[1], 2))
		else $error("written output level not shown on pin");

	chk_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !ch1_output_enable_bit && !wr |=>
		ch1_output_level == $past(ch1_output_level))
		else $error("output changed while counting is disabled");

	chk_filter_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !ch1_noise_filter_bit |=> ch1_input_clean == $past(ch1_input_pin))
		else $error("filter off yet input delayed");

	chk_opclk_sel: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !ch2_mode_reg.count_clk_src &&
		ch2_mode_reg.opclk_sel == tmr_cfg_pkg::OPCLK_C |=>
		ch2_count_tick == $past(prescaled_ticks[2]))
		else $error("operation clock c not selected");

	chk_edge_count: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch2_mode_reg.count_clk_src &&
		ch2_mode_reg.edge_sel == tmr_cfg_pkg::EDGE_RISE |=>
		ch2_count_tick == $past(ch2_rise))
		else $error("count tick not from input rising edge");

	chk_lead_role: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> ch2_lead_role_bit == $past(ch2_mode_reg[11]))
		else $error("lead role output does not follow mode bit 11");

	chk_sw_only: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch2_mode_reg.trig_sel == tmr_cfg_pkg::TRIG_SW_ONLY |=>
		ch2_start_trig == $past(sw_trig) && !ch2_capture_trig)
		else $error("non-software trigger accepted in code 000");

	chk_one_edge: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch2_mode_reg.trig_sel == tmr_cfg_pkg::TRIG_ONE_EDGE &&
		valid_edge |=> ch2_start_trig && ch2_capture_trig)
		else $error("valid edge did not start and capture");

	chk_both_edge: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch2_mode_reg.trig_sel == tmr_cfg_pkg::TRIG_BOTH_EDGE &&
		ch2_mode_reg.edge_sel == tmr_cfg_pkg::EDGE_BOTH_LOW && ch2_rise |=>
		ch2_capture_trig)
		else $error("rising edge did not capture in low width mode");

	chk_master_trig: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && ch2_mode_reg.trig_sel == tmr_cfg_pkg::TRIG_MASTER |=>
		ch2_capture_trig == $past(master_irq))
		else $error("master interrupt not used as trigger");

	chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && psel && penable && !pready ##1 clk_en |-> pready)
		else $error("bus answer missing after one wait state");

endmodule : timer_channel_cfg

/* test/pin_model.sv */
module pin_model (
	input wire logic pclk,
	output logic ch1_input_pin,
	output logic ch2_input_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		ch1_input_pin = 1'b0;
		ch2_input_pin = 1'b0;
	end

	// Pin levels move only just after a rising edge
	task automatic set_pin(input int w, input logic v);
		@(posedge pclk);
		if (w == 1) begin
			ch1_input_pin <= v;
		end else begin
			ch2_input_pin <= v;
		end
	endtask : set_pin
endmodule : pin_model

/* test/tb.sv */
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %0h got %0h", nm, e, g); \
	end end

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] ev = 8'h00;
	logic clk_en = 1'b1;
	logic cnt_zero = 1'b0;
	logic ch1_in, ch2_in, out_pin, clean, lead, st, cap, tk;
	int miscompares = 0;
	int checks_done = 0;
	int n_st, n_cap, n_tk, n_cl;
	logic [31:0] rd;
	logic err;
	logic [15:0] tmode [8] = '{16'h0040, 16'h1140, 16'h0100, 16'h0280,
		16'h02c0, 16'h10c0, 16'h1000, 16'h0400};
	logic [11:0] trise [8] = '{12'h000, 12'h111, 12'h000, 12'h010,
		12'h100, 12'h001, 12'h000, 12'h000};
	logic [11:0] tfall [8] = '{12'h000, 12'h111, 12'h110, 12'h110,
		12'h110, 12'h002, 12'h001, 12'h000};
	int tickbit [4] = '{0, 2, 1, 3};

	always #25 pclk = ~pclk;

	timer_channel_cfg u_dut (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.prescaled_ticks(ev[3:0]), .ch1_input_pin(ch1_in),
		.ch2_input_pin(ch2_in), .ch1_cnt_toggle(ev[4]),
		.ch1_cnt_set(ev[5]), .ch1_cnt_clear(ev[6]), .master_irq(ev[7]),
		.ch1_output_pin(out_pin), .ch1_input_clean(clean),
		.ch2_lead_role_bit(lead), .ch2_start_trig(st),
		.ch2_capture_trig(cap), .ch2_count_tick(tk)
	);

	pin_model u_pins (
		.pclk(pclk), .ch1_input_pin(ch1_in), .ch2_input_pin(ch2_in)
	);

	// ------------------------------------------------------------
	// Pulse counters on design outputs
	// ------------------------------------------------------------
	always @(posedge pclk) begin
		if (cnt_zero) begin
			n_st <= 0;
			n_cap <= 0;
			n_tk <= 0;
			n_cl <= 0;
		end else begin
			n_st <= n_st + int'(st === 1'b1);
			n_cap <= n_cap + int'(cap === 1'b1);
			n_tk <= n_tk + int'(tk === 1'b1);
			n_cl <= n_cl + int'(clean === 1'b1);
		end
	end

	task automatic final_report;
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input logic [7:0] m);
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 8'h00;
		repeat (4) @(posedge pclk);
	endtask : pulse

	// Counters are cleared by their own process, one edge after request
	task automatic clr;
		@(posedge pclk);
		cnt_zero <= 1'b1;
		@(posedge pclk);
		cnt_zero <= 1'b0;
	endtask : clr

	task automatic pin(input int w, input logic v);
		u_pins.set_pin(w, v);
		repeat (6) @(posedge pclk);
	endtask : pin

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		final_report();
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and the unmapped hole
		for (int a = 0; a <= 16; a += 4) begin
			apb(8'(a), 1'b0, 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		apb(8'h1c, 1'b0, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		apb(8'h00, 1'b1, 32'hffffffff);
		apb(8'h00, 1'b0, 32'h0);
		`CHK("mode width", 32'h0000ffff, rd)
		apb(8'h0c, 1'b1, 32'h000001ff);
		apb(8'h0c, 1'b0, 32'h0);
		`CHK("filter width", 32'h000000ff, rd)
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h0c, 1'b1, 32'h0);
		apb(8'h10, 1'b1, 32'h0000dcff);
		apb(8'h10, 1'b0, 32'h0);
		`CHK("ch2 mode rb", 32'h0000dccf, rd)
		`CHK("lead role", 1'b1, lead)
		// Output level, enable and mode
		apb(8'h04, 1'b1, 32'h2);
		repeat (3) @(posedge pclk);
		`CHK("out high", 1'b1, out_pin)
		apb(8'h04, 1'b1, 32'h0);
		repeat (3) @(posedge pclk);
		`CHK("out low", 1'b0, out_pin)
		apb(8'h08, 1'b1, 32'h2);
		apb(8'h04, 1'b1, 32'h2);
		repeat (3) @(posedge pclk);
		`CHK("write ignored", 1'b0, out_pin)
		pulse(8'h10);
		`CHK("toggle", 1'b1, out_pin)
		apb(8'h00, 1'b1, 32'h2);
		pulse(8'h40);
		`CHK("slave clear", 1'b0, out_pin)
		pulse(8'h20);
		`CHK("slave set", 1'b1, out_pin)
		apb(8'h08, 1'b1, 32'h0);
		pulse(8'h40);
		`CHK("count blocked", 1'b1, out_pin)
		// Input noise filter
		apb(8'h0c, 1'b1, 32'h2);
		clr();
		u_pins.set_pin(1, 1'b1);
		u_pins.set_pin(1, 1'b0);
		repeat (8) @(posedge pclk);
		`CHK("glitch held", 0, n_cl)
		pin(1, 1'b1);
		`CHK("steady passed", 1'b1, clean)
		apb(8'h18, 1'b0, 32'h0);
		`CHK("status", 32'h5, rd)
		pin(1, 1'b0);
		apb(8'h0c, 1'b1, 32'h0);
		clr();
		u_pins.set_pin(1, 1'b1);
		u_pins.set_pin(1, 1'b0);
		repeat (8) @(posedge pclk);
		`CHK("glitch passed", 1'b1, n_cl > 0)
		// Operation clock selection
		for (int i = 0; i < 4; i++) begin
			apb(8'h10, 1'b1, {16'h0, 2'(i), 14'h0});
			clr();
			pulse(8'h0f & ~(8'h01 << tickbit[i]));
			`CHK("other ticks", 0, n_tk)
			pulse(8'h01 << tickbit[i]);
			`CHK("chosen tick", 1, n_tk)
		end
		// Trigger codes and edges, legal codes only
		for (int i = 0; i < 8; i++) begin
			apb(8'h10, 1'b1, {16'h0, tmode[i]});
			clr();
			pin(2, 1'b1);
			`CHK("rise", trise[i], {n_st[3:0], n_cap[3:0], n_tk[3:0]})
			pin(2, 1'b0);
			`CHK("fall", tfall[i], {n_st[3:0], n_cap[3:0], n_tk[3:0]})
		end
		`CHK("lead clear", 1'b0, lead)
		pulse(8'h80);
		`CHK("master irq", 12'h110, {n_st[3:0], n_cap[3:0], n_tk[3:0]})
		apb(8'h10, 1'b1, 32'h0);
		clr();
		apb(8'h14, 1'b1, 32'h1);
		repeat (4) @(posedge pclk);
		`CHK("sw start", 12'h100, {n_st[3:0], n_cap[3:0], n_tk[3:0]})
		// Clock enable low freezes the tick path
		clr();
		@(posedge pclk);
		clk_en <= 1'b0;
		pulse(8'h01);
		`CHK("frozen tick", 0, n_tk)
		@(posedge pclk);
		clk_en <= 1'b1;
		pulse(8'h01);
		`CHK("live tick", 1, n_tk)
		final_report();
	end
endmodule : tb
